// ===== hdl/adsp_pkg.sv
// Package with register offsets, field layouts, reset values and types of the strobe port.
package adsp_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_PORT2_EXT_POLARITY    = 8'hAE;
	localparam logic [7:0] OFF_STROBE_CTRL_LOW_PINS  = 8'hC2;
	localparam logic [7:0] OFF_STROBE_CTRL_HIGH_PINS = 8'hC3;
	localparam logic [7:0] OFF_AUX_PORT_DATA         = 8'hD8;
	// Base address registers: pin n high byte at BASE + 2n, low byte at BASE + 2n + 1.
	localparam logic [7:0] OFF_BASE_ADDR_FIRST       = 8'hE0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_CTRL      = 8'h00;
	localparam logic [7:0] RST_POLARITY  = 8'h00;
	localparam logic [7:0] RST_BASE      = 8'h00;
	localparam logic [7:0] RST_PORT_DATA = 8'hFF;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int NUM_PINS        = 4;
	localparam int POL_LSB         = 4;
	localparam int PIN_FIELD_WIDTH = 4;
	localparam int FUNC_LSB        = 2;
	localparam int CMP_LSB         = 0;
	localparam logic [7:0] POL_WRITE_MASK  = 8'hFC;
	localparam logic [7:0] DATA_WRITE_MASK = 8'h0F;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		FUNC_GPIO  = 2'h0,
		FUNC_READ  = 2'h1,
		FUNC_WRITE = 2'h2,
		FUNC_BOTH  = 2'h3
	} adsp_func_t;

	typedef enum logic [1:0] {
		CMP_FULL  = 2'h0,
		CMP_A15_1 = 2'h1,
		CMP_A15_2 = 2'h2,
		CMP_A15_8 = 2'h3
	} adsp_cmp_t;

	typedef struct packed {
		adsp_func_t func;
		adsp_cmp_t  cmp;
		logic       polarity;
		logic       data;
		logic [15:0] base;
	} adsp_pin_cfg_t;

	typedef struct packed {
		logic        rd_strobe;
		logic        wr_strobe;
		logic [15:0] addr;
	} adsp_access_t;

endpackage

// ===== hdl/adsp_pin.sv
// One strobe port pin: address window compare and output selection.
`timescale 1ns/1ps
module adsp_pin (
	input  wire adsp_pkg::adsp_pin_cfg_t cfg_in,
	input  wire adsp_pkg::adsp_access_t  acc_in,
	output logic                         next_pin_out
);
	logic [15:0] mask;
	logic        hit;
	logic        active;

	always_comb begin
		unique case (cfg_in.cmp)
			adsp_pkg::CMP_FULL:  mask = 16'hFFFF;
			adsp_pkg::CMP_A15_1: mask = 16'hFFFE;
			adsp_pkg::CMP_A15_2: mask = 16'hFFFC;
			adsp_pkg::CMP_A15_8: mask = 16'hFF00;
		endcase
	end

	assign hit = ((acc_in.addr ^ cfg_in.base) & mask) == 16'h0000;

	always_comb begin
		unique case (cfg_in.func)
			adsp_pkg::FUNC_GPIO:  active = 1'b0;
			adsp_pkg::FUNC_READ:  active = hit & acc_in.rd_strobe;
			adsp_pkg::FUNC_WRITE: active = hit & acc_in.wr_strobe;
			adsp_pkg::FUNC_BOTH:  active = hit & (acc_in.rd_strobe | acc_in.wr_strobe);
		endcase
	end

	// Polarity bit set gives an active-high strobe; cleared gives active low.
	always_comb begin
		if (cfg_in.func == adsp_pkg::FUNC_GPIO) begin
			next_pin_out = cfg_in.data;
		end else begin
			next_pin_out = cfg_in.polarity ? active : ~active;
		end
	end
endmodule // adsp_pin

// ===== hdl/adsp_top.sv
// Top of the address-decoded strobe port: register file and four pin drivers.
`timescale 1ns/1ps
module adsp_top (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  sfr_addr_in,
	input  wire logic        sfr_wr_in,
	input  wire logic        sfr_rd_in,
	input  wire logic [7:0]  sfr_wdata_in,
	output logic      [7:0]  sfr_rdata_out,
	output logic             sfr_hit_out,
	input  wire logic [15:0] ext_addr_in,
	input  wire logic        ext_rd_in,
	input  wire logic        ext_wr_in,
	input  wire logic [3:0]  aux_pin_in,
	output logic      [3:0]  aux_pin_out,
	output logic      [3:0]  aux_pin_oe_out
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_sync1;
	logic rst_n;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync1 <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n     <= rst_sync1;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] strobe_ctrl_low_pins;
	logic [7:0] strobe_ctrl_high_pins;
	logic [7:0] port2_ext_polarity;
	logic [7:0] aux_port_data;
	logic [7:0] base_addr_high [adsp_pkg::NUM_PINS];
	logic [7:0] base_addr_low  [adsp_pkg::NUM_PINS];

	logic       base_sel;
	logic [2:0] base_idx;
	logic [7:0] base_offset;

	assign base_offset = sfr_addr_in - adsp_pkg::OFF_BASE_ADDR_FIRST;
	assign base_sel    = (sfr_addr_in >= adsp_pkg::OFF_BASE_ADDR_FIRST) && (base_offset < 8'h08);
	assign base_idx    = base_offset[2:0];

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			strobe_ctrl_low_pins  <= adsp_pkg::RST_CTRL;
			strobe_ctrl_high_pins <= adsp_pkg::RST_CTRL;
		end else if (sfr_wr_in) begin
			if (sfr_addr_in == adsp_pkg::OFF_STROBE_CTRL_LOW_PINS) begin
				strobe_ctrl_low_pins <= sfr_wdata_in;
			end
			if (sfr_addr_in == adsp_pkg::OFF_STROBE_CTRL_HIGH_PINS) begin
				strobe_ctrl_high_pins <= sfr_wdata_in;
			end
		end
	end

	// Bits 1:0 are held at zero by hardware so a careless write cannot set them.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			port2_ext_polarity <= adsp_pkg::RST_POLARITY;
		end else if (sfr_wr_in && sfr_addr_in == adsp_pkg::OFF_PORT2_EXT_POLARITY) begin
			port2_ext_polarity <= sfr_wdata_in & adsp_pkg::POL_WRITE_MASK;
		end
	end

	// Reserved upper bits stay at one, matching the all-ones reset value.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			aux_port_data <= adsp_pkg::RST_PORT_DATA;
		end else if (sfr_wr_in && sfr_addr_in == adsp_pkg::OFF_AUX_PORT_DATA) begin
			aux_port_data <= (sfr_wdata_in & adsp_pkg::DATA_WRITE_MASK) | ~adsp_pkg::DATA_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < adsp_pkg::NUM_PINS; i++) begin
				base_addr_high[i] <= adsp_pkg::RST_BASE;
				base_addr_low[i]  <= adsp_pkg::RST_BASE;
			end
		end else if (sfr_wr_in && base_sel) begin
			if (base_idx[0]) begin
				base_addr_low[base_idx[2:1]] <= sfr_wdata_in;
			end else begin
				base_addr_high[base_idx[2:1]] <= sfr_wdata_in;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read side
	// ------------------------------------------------------------------
	logic [7:0] next_rdata;
	logic       next_hit;

	// Port data reads return the pin levels in the low nibble, as a standard port does.
	always_comb begin
		next_hit   = 1'b1;
		next_rdata = 8'h00;
		if (base_sel) begin
			next_rdata = base_idx[0] ? base_addr_low[base_idx[2:1]] : base_addr_high[base_idx[2:1]];
		end else begin
			unique case (sfr_addr_in)
				adsp_pkg::OFF_STROBE_CTRL_LOW_PINS:  next_rdata = strobe_ctrl_low_pins;
				adsp_pkg::OFF_STROBE_CTRL_HIGH_PINS: next_rdata = strobe_ctrl_high_pins;
				adsp_pkg::OFF_PORT2_EXT_POLARITY:    next_rdata = port2_ext_polarity;
				adsp_pkg::OFF_AUX_PORT_DATA:         next_rdata = {aux_port_data[7:4], aux_pin_in};
				default:                             next_hit   = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_out <= 8'h00;
			sfr_hit_out   <= 1'b0;
		end else begin
			sfr_rdata_out <= sfr_rd_in ? next_rdata : 8'h00;
			sfr_hit_out   <= sfr_rd_in & next_hit;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	adsp_pkg::adsp_access_t  acc;
	adsp_pkg::adsp_pin_cfg_t cfg [adsp_pkg::NUM_PINS];
	logic [15:0]             ctrl_pair;
	logic [3:0]              next_pin;

	assign acc.rd_strobe = ext_rd_in;
	assign acc.wr_strobe = ext_wr_in;
	assign acc.addr      = ext_addr_in;
	assign ctrl_pair     = {strobe_ctrl_high_pins, strobe_ctrl_low_pins};

	for (genvar g = 0; g < adsp_pkg::NUM_PINS; g++) begin : g_pin
		assign cfg[g].func     = adsp_pkg::adsp_func_t'(ctrl_pair[g*adsp_pkg::PIN_FIELD_WIDTH+adsp_pkg::FUNC_LSB +: 2]);
		assign cfg[g].cmp      = adsp_pkg::adsp_cmp_t'(ctrl_pair[g*adsp_pkg::PIN_FIELD_WIDTH+adsp_pkg::CMP_LSB +: 2]);
		assign cfg[g].polarity = port2_ext_polarity[adsp_pkg::POL_LSB+g];
		assign cfg[g].data     = aux_port_data[g];
		assign cfg[g].base     = {base_addr_high[g], base_addr_low[g]};

		adsp_pin u_pin (
			.cfg_in       (cfg[g]),
			.acc_in       (acc),
			.next_pin_out (next_pin[g])
		);
	end

	// Registering the pins adds one cycle; the core keeps its strobe up longer than that.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			aux_pin_out    <= 4'hF;
			aux_pin_oe_out <= 4'h0;
		end else begin
			aux_pin_out <= next_pin;
			for (int i = 0; i < adsp_pkg::NUM_PINS; i++) begin
				// Mode 0 drives only a low level; the pull-up gives the high, like a standard port.
				aux_pin_oe_out[i] <= (cfg[i].func != adsp_pkg::FUNC_GPIO) | ~next_pin[i];
			end
		end
	end
endmodule // adsp_top

// ===== verification/adsp_periph.sv
// Peripheral side of the strobe pins: pull-ups and the resolved pin level.
`timescale 1ns/1ps
module adsp_periph (
	input  wire logic [3:0] pin_out_in,
	input  wire logic [3:0] pin_oe_in,
	output logic      [3:0] pin_level_out
);
	// A released pin is pulled high, so a stale driven value is never read back.
	always_comb
		for (int i = 0; i < 4; i++)
			pin_level_out[i] = pin_oe_in[i] ? pin_out_in[i] : 1'b1;
endmodule // adsp_periph

// ===== verification/adsp_props.sv
// Assertion checker for the strobe port top.
`timescale 1ns/1ps
module adsp_props (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [7:0]  sfr_addr_in,
	input wire logic        sfr_wr_in,
	input wire logic        sfr_rd_in,
	input wire logic [7:0]  sfr_wdata_in,
	input wire logic [7:0]  sfr_rdata_out,
	input wire logic        sfr_hit_out,
	input wire logic [15:0] ext_addr_in,
	input wire logic        ext_rd_in,
	input wire logic        ext_wr_in,
	input wire logic [3:0]  aux_pin_in,
	input wire logic [3:0]  aux_pin_out,
	input wire logic [3:0]  aux_pin_oe_out
);
	logic [7:0] ctrl_lo;
	logic       pol0;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Shadow copies of the lower control byte and pin 0 polarity.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_lo <= 8'h00;
			pol0    <= 1'b0;
		end else if (sfr_wr_in && sfr_addr_in == 8'hC2) begin
			ctrl_lo <= sfr_wdata_in;
		end else if (sfr_wr_in && sfr_addr_in == 8'hAE) begin
			pol0 <= sfr_wdata_in[4];
		end
	end
	AST_IDLE_LEVEL:
		assert property ($past(ctrl_lo[3:2] != 2'h0 && !ext_rd_in && !ext_wr_in)
			|-> aux_pin_out[0] == !$past(pol0)) else $error("strobe active when idle");
	AST_READ_ONLY:
		assert property ($past(ctrl_lo[3:2] == 2'h1 && !ext_rd_in)
			|-> aux_pin_out[0] == !$past(pol0)) else $error("read strobe without read");
	AST_WRITE_ONLY:
		assert property ($past(ctrl_lo[3:2] == 2'h2 && !ext_wr_in)
			|-> aux_pin_out[0] == !$past(pol0)) else $error("write strobe without write");
	AST_STROBE_DRIVE:
		assert property ($past(ctrl_lo[3:2] != 2'h0) |-> aux_pin_oe_out[0]) else $error("strobe not driven");
	AST_GPIO_PULL:
		assert property ((aux_pin_out | aux_pin_oe_out) == 4'hF) else $error("released pin not high");
	AST_CTRL_READ:
		assert property (sfr_rd_in && sfr_addr_in == 8'hC2 |=> sfr_hit_out && sfr_rdata_out == $past(ctrl_lo))
			else $error("control read back wrong");
	AST_DATA_READ:
		assert property (sfr_rd_in && sfr_addr_in == 8'hD8 |=> sfr_rdata_out == {4'hF, $past(aux_pin_in)})
			else $error("port data read back wrong");
	AST_POL_LOW:
		assert property (sfr_rd_in && sfr_addr_in == 8'hAE |=> sfr_rdata_out[1:0] == 2'h0)
			else $error("polarity low bits not zero");
endmodule // adsp_props
bind adsp_top adsp_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
	.sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.sfr_hit_out(sfr_hit_out), .ext_addr_in(ext_addr_in), .ext_rd_in(ext_rd_in), .ext_wr_in(ext_wr_in),
	.aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out), .aux_pin_oe_out(aux_pin_oe_out));

// ===== verification/addr_decode_strobe_port_tb.sv
// Self-checking bench for the address-decoded strobe port.
`timescale 1ns/1ps
module addr_decode_strobe_port_tb;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [15:0] ext_addr = 16'h0000;
	logic        ext_rd = 1'b0;
	logic        ext_wr = 1'b0;
	logic [7:0]  rdata;
	logic        hit;
	logic [3:0]  pin_lvl;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic [15:0] ofs [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0100};
	int          num_errors = 0;
	int          checks = 0;
	always #10 clk_in = ~clk_in;
	adsp_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr),
		.sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
		.ext_addr_in(ext_addr), .ext_rd_in(ext_rd), .ext_wr_in(ext_wr), .aux_pin_in(pin_lvl),
		.aux_pin_out(pin_out), .aux_pin_oe_out(pin_oe));
	adsp_periph u_periph (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .pin_level_out(pin_lvl));
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk_in) #1 sfr_wr = 1'b0;
		@(posedge clk_in) #1;
	endtask
	task automatic rd(input logic [7:0] a, exp, input logic eh);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk_in) #1 sfr_rd = 1'b0;
		check("rdata", rdata, exp);
		check("hit", hit, eh);
		@(posedge clk_in) #1;
	endtask
	// Expected strobe activity from mode, compare width, base and access kind.
	function automatic logic act(input logic [1:0] f, c, input logic [15:0] b, a, input logic r, w);
		logic [15:0] m;
		m = (c == 2'h0) ? 16'hFFFF : (c == 2'h1) ? 16'hFFFE : (c == 2'h2) ? 16'hFFFC : 16'hFF00;
		return ((r && f[0]) || (w && f[1])) && ((a & m) == (b & m));
	endfunction
	task automatic t_reset;
		check("pins", {pin_oe, pin_out}, 8'h0F);
		rd(8'hC2, 8'h00, 1'b1);
		rd(8'hC3, 8'h00, 1'b1);
		rd(8'hAE, 8'h00, 1'b1);
		for (int i = 0; i < 8; i++) rd(8'hE0 + 8'(i), 8'h00, 1'b1);
		rd(8'hD8, 8'hFF, 1'b1);
		rd(8'h00, 8'h00, 1'b0);
		wr(8'hAE, 8'hF0);
		rd(8'hAE, 8'hF0, 1'b1);
		wr(8'hAE, 8'h00);
	endtask
	task automatic t_gpio;
		wr(8'hD8, 8'hF5);
		check("pins", {pin_oe, pin_out}, 8'hA5);
		rd(8'hD8, 8'hF5, 1'b1);
		wr(8'hD8, 8'hFF);
	endtask
	task automatic t_strobe;
		logic [15:0] b;
		logic [7:0]  cf;
		logic        pol;
		for (int p = 0; p < 4; p++) for (int f = 1; f < 4; f++) for (int c = 0; c < 4; c++) begin
			b = {4'(p), 12'h9C6};
			cf = 8'({2'(f), 2'(c)}) << (4 * (p % 2));
			pol = c[0];
			wr(8'hE0 + 8'(2 * p), b[15:8]);
			wr(8'hE1 + 8'(2 * p), b[7:0]);
			wr(8'hAE, 8'(pol) << (4 + p));
			wr(8'hC2, p < 2 ? cf : 8'h00);
			wr(8'hC3, p < 2 ? 8'h00 : cf);
			rd(p < 2 ? 8'hC2 : 8'hC3, cf, 1'b1);
			for (int k = 0; k < 10; k++) begin
				ext_addr = b ^ ofs[k / 2];
				ext_rd = k[0];
				ext_wr = !k[0];
				@(posedge clk_in) #1 {ext_rd, ext_wr} = 2'b00;
				check("strobe", pin_out[p], pol == act(2'(f), 2'(c), b, ext_addr, k[0], !k[0]));
				check("oe", pin_oe, 4'h1 << p);
				@(posedge clk_in) #1;
				check("idle", pin_out[p], !pol);
			end
		end
	endtask
	task automatic finish_test;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		t_reset;
		t_gpio;
		t_strobe;
		finish_test;
	end
	// The full run needs about 1600 cycles; this limit leaves wide margin.
	initial begin
		repeat (10000) @(posedge clk_in);
		num_errors++;
		finish_test;
	end
endmodule // addr_decode_strobe_port_tb
